// ### hw/mra_regs.vh
// register offsets, field positions and timing counts for the monitor readout block
`ifndef MRA_REGS_VH
`define MRA_REGS_VH
`define MRA_CH_TEMP       3'd0
`define MRA_CH_SUPPLY     3'd1
`define MRA_CH_EXT_A      3'd2
`define MRA_CH_EXT_B      3'd3
`define MRA_CH_EXT_C      3'd4
`define MRA_NUM_CH        5
`define MRA_OFF_RESULT0   12'h000
`define MRA_OFF_HILIM0    12'h020
`define MRA_OFF_LOLIM0    12'h040
`define MRA_OFF_STATUS    12'h060
`define MRA_OFF_IRQEN     12'h064
`define MRA_OFF_CTRL      12'h068
`define MRA_OFF_LUT_RES0  12'h400
`define MRA_OFF_LUT_RES1  12'h600
`define MRA_OFF_WIPER     12'h06c
`define MRA_ST_DONE_LSB   0
`define MRA_ST_HI_LSB     8
`define MRA_ST_LO_LSB     16
`define MRA_CTRL_MPROT    0
`define MRA_CTRL_APROT    1
`define MRA_CTRL_TEMPIDX  2
`define MRA_CTRL_AUXSEL   3
`define MRA_LUT_FIRST     8'h80
`define MRA_LUT_LAST      8'hc7
`define MRA_LUT_DEPTH     72
`define MRA_FRAME_MS      25
`define MRA_CLK_KHZ       125000
`define MRA_FRAME_CYC     (`MRA_FRAME_MS * `MRA_CLK_KHZ)
`endif

// ### hw/mra_monitor.v
// monitor readout, limit alarms, open-drain buffers and temperature-indexed resistor lookup
// Contract
// [RL1] results are 16-bit, upper 12 bits meaningful
// [RL2] reader masks the low four bits
// [RL3] channels refreshed round-robin, once per frame
// [RL4] frame lasts 25 ms typ, 36 ms max
// [RL5] per-channel done bit after each conversion
// [RL6] results compared to high and low limits
// [RL7] per-channel alarm interrupt enable
// [RL8] alarm can pull buffer output a
// [RL9] two buffers, logic input to open-drain
// [RL10] temperature two's complement, others unsigned
// [RL11] full scale 7fff/8000 or ffff/0000
// [RL12] reader weights supply at 100 uV
// [RL13] reader weights inputs at 38.147 uV
// [RL14] two resistors, setting per 2 degrees
// [RL15] index 80h..c7h, clamped at ends
// [RL16] low protect pin means unprotected
// [RL17] main blocked by pin and bit; aux by bit
// [RL18] host clocks serial data both ways
// [RL19] buffer outputs follow inputs non-inverting
// [RL20] flags stay set until software clears
`include "mra_regs.vh"
`default_nettype none
module mra_monitor #(
  parameter FRAME_CYC = `MRA_FRAME_CYC
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // converter side: raw 12-bit sample for the selected channel
  output reg  [2:0]  conv_channel,
  output reg         conv_start,
  input  wire [11:0] conv_sample,
  input  wire        conv_valid,
  // pins
  input  wire        buffer_input_a,
  input  wire        buffer_input_b,
  input  wire        write_protect_pin,
  output wire        buffer_output_a_o,
  output wire        buffer_output_a_oe,
  output wire        buffer_output_b_o,
  output wire        buffer_output_b_oe,
  // resistor settings and alarm interrupt
  output reg  [7:0]  wiper0_r,
  output reg  [7:0]  wiper1_r,
  output wire        alarm_irq
);
  localparam [31:0] SLOT_CYC = FRAME_CYC / `MRA_NUM_CH;
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_CONV = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;

  // pin synchronisers; preset high so no false pull follows reset
  reg [1:0] sync_a_r;
  reg [1:0] sync_b_r;
  reg [1:0] sync_wp_r;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      sync_a_r <= 2'b11;
    end else begin
      sync_a_r <= {sync_a_r[0], buffer_input_a};
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      sync_b_r <= 2'b11;
    end else begin
      sync_b_r <= {sync_b_r[0], buffer_input_b};
    end
  end

  // preset high: a floating pin protects
  always @(posedge sys_clk) begin
    if (!nrst) begin
      sync_wp_r <= 2'b11;
    end else begin
      sync_wp_r <= {sync_wp_r[0], write_protect_pin}; // RL16
    end
  end

  reg [15:0] result_r [0:4];
  reg [15:0] hilim_r  [0:4];
  reg [15:0] lolim_r  [0:4];
  reg [7:0]  lut0_r   [0:`MRA_LUT_DEPTH-1];
  reg [7:0]  lut1_r   [0:`MRA_LUT_DEPTH-1];
  reg [4:0]  done_r;
  reg [4:0]  hi_r;
  reg [4:0]  lo_r;
  reg [4:0]  irqen_r;
  reg [3:0]  ctrl_r;
  reg [1:0]  state_r;
  reg [31:0] slot_cnt_r;
  integer    i;
  integer    j;

  // true when addr falls inside a bank of five word registers
  function in_bank;
    input [11:0] addr;
    input [11:0] base;
    begin
      in_bank = (addr >= base) && (addr < base + 12'h014);
    end
  endfunction

  // signed compare for temperature, unsigned for the rest
  function above;
    input [2:0]  ch;
    input [15:0] a;
    input [15:0] b;
    begin
      if (ch == `MRA_CH_TEMP)
        above = $signed(a) > $signed(b); // RL10
      else
        above = a > b;
    end
  endfunction

  // left-justify the 12-bit sample; low nibble zero
  wire [15:0] sample_w = {conv_sample, 4'h0}; // RL1 RL11

  // apb decode: single-cycle answer
  wire        acc_w   = psel & penable;
  wire        wr_w    = acc_w & pwrite;
  wire        in_lut0 = paddr >= `MRA_OFF_LUT_RES0 && paddr < `MRA_OFF_LUT_RES1;
  // upper bound stops 0x800 and above aliasing onto the second table
  wire        in_lut1 = paddr >= `MRA_OFF_LUT_RES1 && paddr < `MRA_OFF_LUT_RES1 + 12'h200;
  wire [6:0]  lut_ix  = paddr[8:2];
  wire [2:0]  reg_ix  = paddr[4:2];
  // aux-select bit routes writes as auxiliary-address writes
  wire        prot_main = sync_wp_r[1] & ctrl_r[`MRA_CTRL_MPROT]; // RL16 RL17
  wire        prot_aux  = ctrl_r[`MRA_CTRL_APROT]; // RL17
  wire        blocked   = ctrl_r[`MRA_CTRL_AUXSEL] ? prot_aux : prot_main;
  // status and interrupt-enable stay writable, like volatile scratch space
  wire        is_status = paddr == `MRA_OFF_STATUS;
  wire        is_irqen  = paddr == `MRA_OFF_IRQEN;
  wire        is_ctrl   = paddr == `MRA_OFF_CTRL;
  wire        is_hi     = in_bank(paddr, `MRA_OFF_HILIM0);
  wire        is_lo     = in_bank(paddr, `MRA_OFF_LOLIM0);
  wire        is_res    = in_bank(paddr, `MRA_OFF_RESULT0);
  wire        is_wip    = paddr == `MRA_OFF_WIPER;
  wire        lut_ok    = lut_ix < `MRA_LUT_DEPTH;
  wire        mapped    = is_status | is_irqen | is_ctrl | is_hi | is_lo | is_res | is_wip
                          | ((in_lut0 | in_lut1) & lut_ok);
  wire        wr_ok     = wr_w & mapped & !is_res & (is_status | is_irqen | !blocked);
  // zero wait states: every access completes in its first cycle
  assign pready  = 1'b1; // RL18
  assign pslverr = acc_w & (!mapped | (pwrite & is_res) | (pwrite & !wr_ok & mapped));

  // conversion sequencer
  always @(posedge sys_clk) begin
    if (!nrst) begin
      state_r      <= ST_IDLE;
      conv_channel <= 3'd0;
      conv_start   <= 1'b0;
      slot_cnt_r   <= 32'd0;
    end else begin
      conv_start <= 1'b0;
      if (slot_cnt_r != 32'd0)
        slot_cnt_r <= slot_cnt_r - 32'd1;
      case (state_r)
        ST_IDLE: begin
          conv_start <= 1'b1;
          slot_cnt_r <= SLOT_CYC - 32'd1; // RL4
          state_r    <= ST_CONV;
        end
        ST_CONV: begin
          if (conv_valid)
            state_r <= ST_WAIT;
        end
        default: begin
          if (slot_cnt_r == 32'd0) begin
            conv_channel <= (conv_channel == `MRA_CH_EXT_C) ? `MRA_CH_TEMP
                            : conv_channel + 3'd1; // RL3
            state_r      <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // converter answer and its limit comparisons
  wire cap_w = (state_r == ST_CONV) && conv_valid;
  wire hi_w  = above(conv_channel, sample_w, hilim_r[conv_channel]); // RL6
  wire lo_w  = above(conv_channel, lolim_r[conv_channel], sample_w); // RL6

  // limit registers
  always @(posedge sys_clk) begin
    if (!nrst) begin
      for (i = 0; i < `MRA_NUM_CH; i = i + 1) begin
        hilim_r[i] <= 16'hffff;
        lolim_r[i] <= 16'h0000;
      end
    end else begin
      if (wr_ok && is_hi) begin
        hilim_r[reg_ix] <= pwdata[15:0]; // RL6
      end
      if (wr_ok && is_lo) begin
        lolim_r[reg_ix] <= pwdata[15:0]; // RL6
      end
    end
  end

  // interrupt enables and control bits
  always @(posedge sys_clk) begin
    if (!nrst) begin
      irqen_r <= 5'h00;
      ctrl_r  <= 4'h0;
    end else begin
      if (wr_ok && is_irqen) begin
        irqen_r <= pwdata[4:0]; // RL7
      end
      if (wr_ok && is_ctrl) begin
        ctrl_r <= pwdata[3:0]; // RL17
      end
    end
  end

  // conversion results
  always @(posedge sys_clk) begin
    if (!nrst) begin
      for (j = 0; j < `MRA_NUM_CH; j = j + 1) begin
        result_r[j] <= 16'h0000;
      end
    end else if (cap_w) begin
      result_r[conv_channel] <= sample_w; // RL1
    end
  end

  // sticky flags: write-one-to-clear, a same-cycle set wins below
  always @(posedge sys_clk) begin
    if (!nrst) begin
      done_r <= 5'h00;
      hi_r   <= 5'h00;
      lo_r   <= 5'h00;
    end else begin
      if (wr_ok && is_status) begin
        done_r <= done_r & ~pwdata[`MRA_ST_DONE_LSB +: 5]; // RL20
        hi_r   <= hi_r & ~pwdata[`MRA_ST_HI_LSB +: 5]; // RL20
        lo_r   <= lo_r & ~pwdata[`MRA_ST_LO_LSB +: 5]; // RL20
      end
      if (cap_w) begin
        done_r[conv_channel] <= 1'b1; // RL5
        if (hi_w) begin
          hi_r[conv_channel] <= 1'b1; // RL6 RL20
        end
        if (lo_w) begin
          lo_r[conv_channel] <= 1'b1; // RL6 RL20
        end
      end
    end
  end

  // lookup tables, one per resistor
  always @(posedge sys_clk) begin
    if (wr_ok && in_lut0 && lut_ok)
      lut0_r[lut_ix] <= pwdata[7:0]; // RL14
    if (wr_ok && in_lut1 && lut_ok)
      lut1_r[lut_ix] <= pwdata[7:0]; // RL14
  end

  // temperature index: 2-degree steps from -40, clamped
  wire signed [15:0] temp_w   = result_r[`MRA_CH_TEMP];
  // high byte is whole degrees, signed; sign must survive the offset
  wire signed [15:0] t_off    = $signed(temp_w[15:8]) + 16'sd40;
  wire [7:0]         step_w   = t_off[8:1];
  wire [7:0]         lut_addr = (t_off < 0) ? `MRA_LUT_FIRST
                                : (step_w > 8'd71) ? `MRA_LUT_LAST
                                : `MRA_LUT_FIRST + step_w; // RL15
  wire [6:0]         tix      = lut_addr[6:0] - 7'd0;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      wiper0_r <= 8'h00;
      wiper1_r <= 8'h00;
    end else if (ctrl_r[`MRA_CTRL_TEMPIDX]) begin
      wiper0_r <= lut0_r[tix]; // RL14 RL15
      wiper1_r <= lut1_r[tix];
    end else if (wr_ok && is_wip) begin
      wiper0_r <= pwdata[7:0];
      wiper1_r <= pwdata[15:8];
    end
  end

  // read mux
  always @(posedge sys_clk) begin
    if (!nrst)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite) begin
      if (is_status)
        prdata <= {11'h0, lo_r, 3'h0, hi_r, 3'h0, done_r};
      else if (is_irqen)
        prdata <= {27'h0, irqen_r};
      else if (is_ctrl)
        prdata <= {27'h0, sync_wp_r[1], ctrl_r};
      else if (is_hi)
        prdata <= {16'h0, hilim_r[reg_ix]};
      else if (is_lo)
        prdata <= {16'h0, lolim_r[reg_ix]};
      else if (is_res)
        prdata <= {16'h0, result_r[reg_ix]};
      else if (is_wip)
        prdata <= {16'h0, wiper1_r, wiper0_r};
      else if (in_lut0 && lut_ok)
        prdata <= {24'h0, lut0_r[lut_ix]};
      else if (in_lut1 && lut_ok)
        prdata <= {24'h0, lut1_r[lut_ix]};
      else
        prdata <= 32'h0;
    end
  end

  // alarm gate and open-drain buffers; low input pulls the pin low
  assign alarm_irq = |((hi_r | lo_r) & irqen_r); // RL7
  assign buffer_output_a_o  = 1'b0;
  assign buffer_output_a_oe = !sync_a_r[1] | alarm_irq; // RL8 RL9 RL19
  assign buffer_output_b_o  = 1'b0;
  assign buffer_output_b_oe = !sync_b_r[1]; // RL9 RL19
endmodule
`default_nettype wire

// ### dv/mra_monitor_checker.sv
// port assertions for the monitor readout block
`default_nettype none
module mra_monitor_checker #(
  parameter int FRAME_CYC = 500
) (
  // watched ports
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [2:0]  conv_channel,
  input wire logic        conv_start,
  input wire logic        buffer_input_b,
  input wire logic        buffer_output_a_o,
  input wire logic        buffer_output_a_oe,
  input wire logic        buffer_output_b_o,
  input wire logic        buffer_output_b_oe,
  input wire logic        alarm_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOT = FRAME_CYC / 5;
  logic [2:0] nch_r;
  logic       seen_r;
  int         gap_r;
  // gap since last start; first start after reset has no reference
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      seen_r <= 1'b0;
      gap_r  <= 0;
    end else begin
      gap_r <= conv_start ? 1 : gap_r + 1;
      if (conv_start) seen_r <= 1'b1;
      if (conv_start) nch_r <= (conv_channel == 3'd4) ? 3'd0 : conv_channel + 3'd1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_rd_setup;
    psel && !penable && !pwrite && paddr < 12'h014;
  endsequence
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access without ready");
  property p_res; s_rd_setup ##1 penable |-> prdata[3:0] == 4'h0; endproperty
  a_res: assert property (p_res) else $error("result low nibble set");
  property p_rot; conv_start && seen_r |-> conv_channel == nch_r; endproperty
  a_rot: assert property (p_rot) else $error("channel order broken");
  property p_gap; conv_start && seen_r |-> gap_r >= SLOT - 2 && gap_r * 25 <= SLOT * 36; endproperty
  a_gap: assert property (p_gap) else $error("slot length out of range");
  property p_od; !buffer_output_a_o && !buffer_output_b_o; endproperty
  a_od: assert property (p_od) else $error("buffer drives high");
  property p_alm; alarm_irq |-> ##[0:2] buffer_output_a_oe; endproperty
  a_alm: assert property (p_alm) else $error("alarm not on output a");
  property p_blo; $fell(buffer_input_b) |-> ##[1:3] buffer_output_b_oe; endproperty
  a_blo: assert property (p_blo) else $error("output b not pulled");
  property p_bhi; $rose(buffer_input_b) |-> ##[1:3] !buffer_output_b_oe; endproperty
  a_bhi: assert property (p_bhi) else $error("output b not released");
endmodule
`default_nettype wire

// ### dv/mra_conv_model.sv
// converter model: answers each start with the selected channel sample
`default_nettype none
module mra_conv_model (
  // request
  input  wire logic        sys_clk,
  input  wire logic        conv_start,
  input  wire logic [2:0]  conv_channel,
  // answer content and delay
  input  wire logic [59:0] smp,
  input  wire logic [3:0]  lag,
  output var  logic [11:0] conv_sample = 12'h0,
  output var  logic        conv_valid = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;
  always @(posedge sys_clk) begin
    conv_valid  <= 1'b0;
    conv_sample <= ~conv_sample; // idle value keeps moving, no stale match
    if (conv_start)
      cnt <= lag;
    else if (cnt == 0) begin
      conv_valid  <= 1'b1;
      conv_sample <= smp[conv_channel*12 +: 12];
      cnt         <= -1;
    end else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// ### dv/tb_monitor_readout_alarm_logic.sv
// testbench for the monitor block with converter model and reference model
`include "mra_regs.vh"
`default_nettype none
module tb_monitor_readout_alarm_logic;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRAME = 500;
  logic        sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic        buffer_input_a = 1, buffer_input_b = 1, write_protect_pin = 1;
  logic [11:0] paddr = 0, conv_sample;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, er, conv_start, conv_valid, alarm_irq;
  logic        buffer_output_a_o, buffer_output_a_oe, buffer_output_b_o, buffer_output_b_oe;
  logic [2:0]  conv_channel;
  logic [7:0]  wiper0_r, wiper1_r;
  logic [59:0] smp = 0;
  logic [3:0]  lag = 0;
  int          fails = 0, comparisons = 0, st = 0, t, i, v;
  int          hi[5] = '{32'h7fff, 32'hffff, 32'hffff, 32'hffff, 32'hffff};
  int          lo[5] = '{32'h8000, 0, 0, 0, 0};
  logic [11:0] tt[4] = '{12'h800, 12'hda0, 12'h000, 12'h7ff};
  mra_monitor #(.FRAME_CYC(FRAME)) uut (.*);
  mra_conv_model cvm (.*);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  // temperature is signed, all other channels unsigned
  function automatic int sg(int x, int c);
    return (c == 0 && x > 32767) ? x - 65536 : x;
  endfunction
  function automatic int flags();
    int f = 0;
    for (int c = 0; c < 5; c++) begin
      if (sg(smp[c*12 +: 12] * 16, c) > sg(hi[c], c)) f |= 1 << (8 + c);
      if (sg(smp[c*12 +: 12] * 16, c) < sg(lo[c], c)) f |= 1 << (16 + c);
    end
    return f;
  endfunction
  // two frames so every channel sees the present sample and limits
  task automatic frame2;
    lag <= 4'($urandom);
    repeat (2 * FRAME + 40) @(posedge sys_clk);
    st |= 32'h1f | flags();
  endtask
  task automatic setlim;
    for (int c = 0; c < 5; c++) begin
      apb(1, `MRA_OFF_HILIM0 + 12'(4 * c), hi[c]);
      apb(1, `MRA_OFF_LOLIM0 + 12'(4 * c), lo[c]);
    end
  endtask
  task automatic rdall;
    for (int c = 0; c < 5; c++) begin
      apb(0, 12'(4 * c), 0);
      chk(rd[15:0], 16'(smp[c*12 +: 12] * 16));
      chk(rd[15:4], smp[c*12 +: 12]);
    end
    apb(0, `MRA_OFF_STATUS, 0);
    chk(rd & 32'h1f1f1f, st);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_sim();
  end
  initial begin
    void'($urandom(4709));
    repeat (10) @(posedge sys_clk);
    nrst <= 1;
    @(posedge sys_clk);
    chk(wiper0_r, 0);
    for (int k = 0; k < 8; k++) begin
      buffer_input_a <= 1'($urandom);
      buffer_input_b <= 1'($urandom);
      repeat (6) @(posedge sys_clk);
      chk(buffer_output_a_oe, !buffer_input_a);
      chk(buffer_output_b_oe, !buffer_input_b);
      chk({buffer_output_a_o, buffer_output_b_o}, 0);
    end
    buffer_input_a <= 1;
    smp = {12'($urandom), 12'h000, 12'($urandom_range(1, 4095)), 12'hfff, 12'h7ff};
    setlim();
    frame2();
    apb(1, `MRA_OFF_STATUS, 32'hffffffff);
    st = 0;
    frame2();
    rdall();
    hi[2] = smp[24 +: 12] * 16 - 16;
    lo[0] = 32'hff00;
    smp[11:0] = 12'h800;
    setlim();
    frame2();
    rdall();
    apb(1, `MRA_OFF_IRQEN, 32'h4);
    chk(alarm_irq, 1);
    chk(buffer_output_a_oe, 1);
    hi[2] = 32'hffff;
    setlim();
    frame2();
    rdall();
    apb(1, `MRA_OFF_STATUS, 32'h400);
    st &= ~32'h400;
    rdall();
    chk(alarm_irq, 0);
    apb(1, `MRA_OFF_IRQEN, 32'h1);
    chk(alarm_irq, 1);
    apb(1, `MRA_OFF_RESULT0, 32'h1234);
    chk(er, 1);
    apb(1, 12'h100, 0);
    chk(er, 1);
    apb(1, `MRA_OFF_CTRL, 32'h4);
    foreach (tt[k]) begin
      smp[11:0] = tt[k];
      t = sg(tt[k] * 16, 0) / 256;
      i = t < -40 ? 0 : t > 102 ? 71 : (t + 40) / 2;
      v = $urandom;
      apb(1, `MRA_OFF_LUT_RES0 + 12'(4 * i), v[7:0]);
      apb(1, `MRA_OFF_LUT_RES1 + 12'(4 * i), v[15:8]);
      frame2();
      chk(wiper0_r, v[7:0]);
      chk(wiper1_r, v[15:8]);
    end
    apb(1, `MRA_OFF_CTRL, 32'h1);
    apb(1, `MRA_OFF_HILIM0, 0);
    chk(er, 1);
    write_protect_pin <= 0;
    repeat (4) @(posedge sys_clk);
    apb(1, `MRA_OFF_HILIM0, 0);
    chk(er, 0);
    apb(1, `MRA_OFF_CTRL, 32'ha);
    apb(1, `MRA_OFF_HILIM0, 0);
    chk(er, 1);
    end_sim();
  end
endmodule
bind mra_monitor mra_monitor_checker #(.FRAME_CYC(FRAME_CYC)) u_chk (.*);
`default_nettype wire
